// ==== hdl/pif_port_irq.sv ====
/*
 Input mode, pull direction, pin event flags and interrupt gating for
 two eight-pin ports and one five-pin port.
 Assumes a one-cycle register strobe port on core_clk_i; pins are async.
*/
// Chosen here: the strobed register port.
`timescale 1ns/10ps
//
// Contract
// - Bit 7 of pull config sets pull-up/down for five-pin port.
// - Bit 6 sets pull direction for port 1, pins 1:0 unpulled.
// - Bit 5 sets pull direction for port 0 pulled pins.
// - Bits 4:0 per-pin mode for port 2: 0 pulled, 1 tristate.
// - Eight port 0 pending flags, 1 pending, reset zero.
// - USB variant: port 0 bit 7 is resume, bit 6 unused.
// - Eight port 1 pending flags, reset zero.
// - Five port 2 pending flags in 4:0, 7:5 read zero.
// - Control bit 5 enables port 2 interrupt requests.
// - Control bit 4 enables port 0 pins 7 to 4.
// - Control bit 3 enables port 0 pins 3 to 0.
// - One edge bit per port: 0 rising, 1 falling.
// - Port 1 per-pin interrupt mask, reset zero, 1 enables.
module pif_port_irq #(
   parameter bit USB_VARIANT = 1'b0
) (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   input wire logic [7:0] port0_pins_i,
   input wire logic [7:0] port1_pins_i,
   input wire logic [4:0] port2_pins_i,
   input wire logic usb_resume_i,
   output logic [7:0] port0_pull_en_o,
   output logic [7:0] port0_pull_down_o,
   output logic [7:0] port1_pull_en_o,
   output logic [7:0] port1_pull_down_o,
   output logic [4:0] port2_pull_en_o,
   output logic [4:0] port2_pull_down_o,
   output logic port0_irq_o,
   output logic port1_irq_o,
   output logic port2_irq_o,
   output logic irq_o
);
   // Port mode inputs from neighbouring blocks are not here; port 0 pins
   // and port 1 pins 7:2 are always taken as pulled, port 1 pins 1:0 never.
   typedef struct packed {
      logic [7:0] p0_flags;
      logic [7:0] p1_flags;
      logic [4:0] p2_flags;
      logic [7:0] pull_cfg;
      logic [7:0] pin_ctl;
      logic [7:0] p1_mask;
      logic [2:0] irq_stat;
      logic [2:0] irq_mask;
      logic [7:0] rdata;
   } pif_state_t;
   pif_state_t st_reg;
   pif_state_t st_next;

   logic [7:0] p0_edge;
   logic [7:0] p1_edge;
   logic [4:0] p2_edge;
   logic [1:0] usb_sync;
   logic usb_last;
   logic usb_edge;
   logic [2:0] req;

   // Select one register byte for reads
   function automatic logic [7:0] read_mux(input pif_state_t s,
                                           input logic [7:0] a);
      logic [7:0] v;
      v = pif_pkg::RST_BYTE;
      unique case (a)
         pif_pkg::ADDR_P0_FLAGS: v = s.p0_flags;
         pif_pkg::ADDR_P1_FLAGS: v = s.p1_flags;
         pif_pkg::ADDR_P2_FLAGS: v = {3'h0, s.p2_flags};
         pif_pkg::ADDR_PIN_CTL: v = s.pin_ctl;
         pif_pkg::ADDR_P1_MASK: v = s.p1_mask;
         pif_pkg::ADDR_P2_PULL: v = s.pull_cfg;
         pif_pkg::ADDR_IRQ_STAT: v = {5'h00, s.irq_stat};
         pif_pkg::ADDR_IRQ_MASK: v = {5'h00, s.irq_mask};
         default: v = pif_pkg::RST_BYTE;
      endcase
      return v;
   endfunction : read_mux

   // Per-pin edge detectors, ports 0, 1 and 2
   // edge per port
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_p0
         pif_edge u_edge (
            .core_clk_i(core_clk_i),
            .rst_b_i(rst_b_i),
            .pin_i(port0_pins_i[gi]),
            .falling_sel_i(st_reg.pin_ctl[pif_pkg::CTL_P0_EDGE_BIT]),
            .edge_o(p0_edge[gi])
         );
         pif_edge u_edge1 (
            .core_clk_i(core_clk_i),
            .rst_b_i(rst_b_i),
            .pin_i(port1_pins_i[gi]),
            .falling_sel_i(st_reg.pin_ctl[pif_pkg::CTL_P1_EDGE_BIT]),
            .edge_o(p1_edge[gi])
         );
      end
      for (gi = 0; gi < 5; gi++) begin : g_p2
         pif_edge u_edge (
            .core_clk_i(core_clk_i),
            .rst_b_i(rst_b_i),
            .pin_i(port2_pins_i[gi]),
            .falling_sel_i(st_reg.pin_ctl[pif_pkg::CTL_P2_EDGE_BIT]),
            .edge_o(p2_edge[gi])
         );
      end
   endgenerate

   // USB resume synchroniser and rising-edge detect
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         usb_sync <= 2'h0;
         usb_last <= 1'b0;
      end else begin
         usb_sync <= {usb_sync[0], usb_resume_i};
         usb_last <= usb_sync[1];
      end
   end
   assign usb_edge = usb_sync[1] & ~usb_last;

   // Port requests from pending flags and enables
   // gate flags by enables
   always_comb begin
      req[0] = (|(st_reg.p0_flags[7:4])
                & st_reg.pin_ctl[pif_pkg::CTL_P0_UP_ALLOW_BIT])
             | (|(st_reg.p0_flags[3:0])
                & st_reg.pin_ctl[pif_pkg::CTL_P0_LO_ALLOW_BIT]);
      req[1] = |(st_reg.p1_flags & st_reg.p1_mask);
      req[2] = |(st_reg.p2_flags)
             & st_reg.pin_ctl[pif_pkg::CTL_P2_ALLOW_BIT];
   end

   // Next state: flags, config and register writes
   always_comb begin
      st_next = st_reg;
      st_next.rdata = pif_pkg::RST_BYTE;
      if (reg_rd_i) begin
         st_next.rdata = read_mux(st_reg, reg_addr_i);
      end
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            pif_pkg::ADDR_P0_FLAGS:
               st_next.p0_flags = st_reg.p0_flags & reg_wdata_i;
            pif_pkg::ADDR_P1_FLAGS:
               st_next.p1_flags = st_reg.p1_flags & reg_wdata_i;
            pif_pkg::ADDR_P2_FLAGS:
               st_next.p2_flags = st_reg.p2_flags & reg_wdata_i[4:0];
            pif_pkg::ADDR_PIN_CTL:
               st_next.pin_ctl = reg_wdata_i & pif_pkg::CTL_WMASK;
            pif_pkg::ADDR_P1_MASK: st_next.p1_mask = reg_wdata_i;
            pif_pkg::ADDR_P2_PULL:
               st_next.pull_cfg = reg_wdata_i & pif_pkg::P2_PULL_WMASK;
            pif_pkg::ADDR_IRQ_STAT:
               st_next.irq_stat = st_reg.irq_stat & ~reg_wdata_i[2:0];
            pif_pkg::ADDR_IRQ_MASK:
               st_next.irq_mask = reg_wdata_i[2:0] & pif_pkg::IRQ_EVT_MASK;
            default: ;
         endcase
      end
      // port 0 flags set on edge, set wins over clear
      if (USB_VARIANT) begin
         // resume flag on top bit, bit 6 unused
         st_next.p0_flags = (st_next.p0_flags & pif_pkg::P0_USB_PIN_MASK)
            | (p0_edge & pif_pkg::P0_USB_PIN_MASK)
            | ({usb_edge, 7'h00})
            | ({st_next.p0_flags[pif_pkg::USB_RESUME_BIT], 7'h00});
      end else begin
         st_next.p0_flags = st_next.p0_flags | p0_edge;
      end
      st_next.p1_flags = st_next.p1_flags | p1_edge;
      // port 2 flags, upper bits absent
      st_next.p2_flags = st_next.p2_flags | p2_edge;
      // Sticky request status, set wins
      st_next.irq_stat = st_next.irq_stat | req;
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Pad control outputs
   // port 0 direction
   assign port0_pull_en_o = 8'hff;
   assign port0_pull_down_o = {8{st_reg.pull_cfg[pif_pkg::P0_PULL_DIR_BIT]}};
   // port 1 direction, low pins unpulled
   assign port1_pull_en_o = pif_pkg::P1_PULL_CAPABLE;
   assign port1_pull_down_o = {8{st_reg.pull_cfg[pif_pkg::P1_PULL_DIR_BIT]}}
                            & pif_pkg::P1_PULL_CAPABLE;
   assign port2_pull_en_o = ~st_reg.pull_cfg[4:0];
   assign port2_pull_down_o = {5{st_reg.pull_cfg[pif_pkg::P2_PULL_DIR_BIT]}}
                            & ~st_reg.pull_cfg[4:0];
   assign port0_irq_o = req[0];
   assign port1_irq_o = req[1];
   assign port2_irq_o = req[2];
   assign irq_o = |(st_reg.irq_stat & st_reg.irq_mask);
   assign reg_rdata_o = st_reg.rdata;
endmodule : pif_port_irq

// ==== hdl/pif_pkg.sv ====
/*
 Package for the port input-mode and pin-interrupt block: register
 offsets, field positions, reset values and masks.
 Assumes an 8-bit register port with an 8-bit address.
*/
package pif_pkg;
   // Register offsets
   localparam logic [7:0] ADDR_P0_FLAGS = 8'h89;
   localparam logic [7:0] ADDR_P1_FLAGS = 8'h8a;
   localparam logic [7:0] ADDR_P2_FLAGS = 8'h8b;
   localparam logic [7:0] ADDR_PIN_CTL = 8'h8c;
   localparam logic [7:0] ADDR_P1_MASK = 8'h8d;
   localparam logic [7:0] ADDR_P2_PULL = 8'hf7;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'hc0;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'hc1;
   // Pull config fields
   localparam int P2_PULL_DIR_BIT = 7;
   localparam int P1_PULL_DIR_BIT = 6;
   localparam int P0_PULL_DIR_BIT = 5;
   localparam logic [7:0] P2_PULL_WMASK = 8'hff;
   // Pin interrupt control fields
   localparam int CTL_P2_ALLOW_BIT = 5;
   localparam int CTL_P0_UP_ALLOW_BIT = 4;
   localparam int CTL_P0_LO_ALLOW_BIT = 3;
   localparam int CTL_P2_EDGE_BIT = 2;
   localparam int CTL_P1_EDGE_BIT = 1;
   localparam int CTL_P0_EDGE_BIT = 0;
   localparam logic [7:0] CTL_WMASK = 8'h7f;
   // Flag layout
   localparam int USB_RESUME_BIT = 7;
   localparam logic [7:0] P0_USB_PIN_MASK = 8'h3f;
   localparam logic [7:0] P2_FLAG_MASK = 8'h1f;
   localparam logic [7:0] P1_PULL_CAPABLE = 8'hfc;
   // Event status bits: port0, port1, port2 requests
   localparam logic [2:0] IRQ_EVT_MASK = 3'h7;
   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [2:0] RST_IRQ = 3'h0;
endpackage : pif_pkg

// ==== hdl/pif_edge.sv ====
/*
 Per-pin input synchroniser and selectable edge detector.
 Assumes asynchronous pins; the edge select is a register on core_clk_i.
*/
`timescale 1ns/10ps
module pif_edge (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic pin_i,
   input wire logic falling_sel_i,
   output logic edge_o
);
   typedef struct packed {
      logic meta;
      logic sync;
      logic last;
      logic [2:0] arm;
   } pif_edge_t;
   pif_edge_t st_reg;
   pif_edge_t st_next;

   // Two-flop sync then history
   always_comb begin
      st_next = st_reg;
      st_next.meta = pin_i;
      st_next.sync = st_reg.meta;
      st_next.last = st_reg.sync;
      // History is trusted only once it holds a real pin sample
      st_next.arm = {st_reg.arm[1:0], 1'b1};
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Rising or falling edge only from synced stages; no false edge
   // from the reset value of the history when a pin idles high
   assign edge_o = st_reg.arm[2] & (falling_sel_i
                                    ? (st_reg.last & ~st_reg.sync)
                                    : (~st_reg.last & st_reg.sync));
endmodule : pif_edge

// ==== verif/pif_port_irq_assertions.sv ====
/* Port checks on the pin-interrupt block.
   Assumes binding to pif_port_irq. */
`timescale 1ns/10ps
module pif_port_irq_assertions (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic [7:0] port0_pull_down_o,
   input wire logic [7:0] port1_pull_en_o,
   input wire logic [7:0] port1_pull_down_o,
   input wire logic [4:0] port2_pull_en_o,
   input wire logic [4:0] port2_pull_down_o,
   input wire logic port0_irq_o,
   input wire logic port1_irq_o,
   input wire logic port2_irq_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);
   // Read data only after a read
   property p_rd_quiet;
      !$past(reg_rd_i) |-> reg_rdata_o == 8'h00;
   endproperty
   a_rd_quiet: assert property (p_rd_quiet) else $error("rdata not idle");
   property p_p2_hi;
      reg_rd_i && reg_addr_i == pif_pkg::ADDR_P2_FLAGS
         |=> reg_rdata_o[7:5] == 3'h0;
   endproperty
   a_p2_hi: assert property (p_p2_hi) else $error("p2 flags 7:5 set");
   property p_p2_pull;
      reg_wr_i && reg_addr_i == pif_pkg::ADDR_P2_PULL
         |=> port2_pull_en_o == ~$past(reg_wdata_i[4:0])
         && port2_pull_down_o == ({5{$past(reg_wdata_i[7])}}
         & ~$past(reg_wdata_i[4:0]));
   endproperty
   a_p2_pull: assert property (p_p2_pull) else $error("p2 pull");
   property p_p0_pull;
      reg_wr_i && reg_addr_i == pif_pkg::ADDR_P2_PULL
         |=> port0_pull_down_o == {8{$past(reg_wdata_i[5])}};
   endproperty
   a_p0_pull: assert property (p_p0_pull) else $error("p0 pull");
   property p_p1_pull;
      port1_pull_en_o == 8'hfc && port1_pull_down_o[1:0] == 2'h0;
   endproperty
   a_p1_pull: assert property (p_p1_pull) else $error("p1 pull");
   property p_p2_dn;
      (port2_pull_down_o & ~port2_pull_en_o) == 5'h00;
   endproperty
   a_p2_dn: assert property (p_p2_dn) else $error("p2 down");
   property p_ctl_off;
      reg_wr_i && reg_addr_i == pif_pkg::ADDR_PIN_CTL
         && reg_wdata_i[5:3] == 3'h0 |=> !port0_irq_o && !port2_irq_o;
   endproperty
   a_ctl_off: assert property (p_ctl_off) else $error("irq on");
   property p_mask_off;
      reg_wr_i && reg_addr_i == pif_pkg::ADDR_P1_MASK
         && reg_wdata_i == 8'h00 |=> !port1_irq_o;
   endproperty
   a_mask_off: assert property (p_mask_off) else $error("p1 irq");
endmodule : pif_port_irq_assertions
bind pif_port_irq pif_port_irq_assertions chk_u (
   .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .port0_pull_down_o(port0_pull_down_o),
   .port1_pull_en_o(port1_pull_en_o), .port1_pull_down_o(port1_pull_down_o),
   .port2_pull_en_o(port2_pull_en_o), .port2_pull_down_o(port2_pull_down_o),
   .port0_irq_o(port0_irq_o), .port1_irq_o(port1_irq_o),
   .port2_irq_o(port2_irq_o));

// ==== verif/pif_pin_model.sv ====
/* Pin model of one port: driven level, else pulled level, else the inverse of the drive value.
   Assumes the bench sets drive enables and levels. */
`timescale 1ns/10ps
module pif_pin_model #(parameter int W = 8) (
   input wire logic [W-1:0] drv_en_i,
   input wire logic [W-1:0] drv_val_i,
   input wire logic [W-1:0] pull_en_i,
   input wire logic [W-1:0] pull_dn_i,
   output logic [W-1:0] pins_o
);
   always_comb begin
      for (int i = 0; i < W; i++) begin
         pins_o[i] = drv_en_i[i] ? drv_val_i[i] :
            pull_en_i[i] ? ~pull_dn_i[i] : ~drv_val_i[i];
      end
   end
endmodule : pif_pin_model

// ==== verif/pif_port_irq_tb.sv ====
/* Register-level bench of the pin-interrupt block.
   Assumes the one-cycle strobe port and synced pins. */
`timescale 1ns/10ps
module pif_port_irq_tb;
   logic core_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic wr = 1'b0, rd = 1'b0;
   logic [7:0] v0 = 8'h00, v1 = 8'hff, p0, p1, pe0, pd0, pe1, pd1;
   logic [4:0] v2 = 5'h00, p2, pe2, pd2;
   logic i0, i1, i2, irq;
   // Pin drive enables, all pins driven by the bench
   logic [7:0] en = 8'hff;
   // resume held low here, so port 0 edge select is free
   logic usb = 1'b0;
   logic [7:0] regs [7] = '{8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'hf7, 8'h10};
   int fail_count = 0;
   int checked = 0;
   always #10 core_clk_i = ~core_clk_i;
   pif_port_irq dut_u (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .port0_pins_i(p0), .port1_pins_i(p1),
      .port2_pins_i(p2), .usb_resume_i(usb), .port0_pull_en_o(pe0),
      .port0_pull_down_o(pd0), .port1_pull_en_o(pe1),
      .port1_pull_down_o(pd1), .port2_pull_en_o(pe2),
      .port2_pull_down_o(pd2), .port0_irq_o(i0), .port1_irq_o(i1),
      .port2_irq_o(i2), .irq_o(irq));
   pif_pin_model #(.W(8)) m0_u (.drv_en_i(en), .drv_val_i(v0),
      .pull_en_i(pe0), .pull_dn_i(pd0), .pins_o(p0));
   pif_pin_model #(.W(8)) m1_u (.drv_en_i(en), .drv_val_i(v1),
      .pull_en_i(pe1), .pull_dn_i(pd1), .pins_o(p1));
   pif_pin_model #(.W(5)) m2_u (.drv_en_i(en[4:0]), .drv_val_i(v2),
      .pull_en_i(pe2), .pull_dn_i(pd2), .pins_o(p2));
   task check(input string n, input logic [7:0] s, input logic [7:0] e);
      checked++;
      if (s !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask : check
   task wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge core_clk_i);
      wr <= 1'b0;
   endtask : wr_reg
   task rd_chk(input string n, input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk_i);
      rd <= 1'b1;
      addr <= a;
      @(posedge core_clk_i);
      rd <= 1'b0;
      #1 check(n, rdata, e);
   endtask : rd_chk
   task settle;
      repeat (6) @(posedge core_clk_i);
      #1;
   endtask : settle
   task stop_test;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : stop_test
   // Watchdog
   initial begin
      #100000;
      fail_count++;
      stop_test();
   end
   // Main sequence
   initial begin
      repeat (2) @(posedge core_clk_i);
      rst_b_i <= 1'b1;
      foreach (regs[i]) rd_chk("reset", regs[i], 8'h00);
      wr_reg(8'h10, 8'hff);
      rd_chk("unmapped", 8'h10, 8'h00);
      check("pe2 rst", {3'h0, pe2}, 8'h1f);
      wr_reg(8'hf7, 8'he5);
      rd_chk("pull", 8'hf7, 8'he5);
      check("pe2", {3'h0, pe2}, 8'h1a);
      check("pd2", {3'h0, pd2}, 8'h1a);
      check("pd1", pd1, 8'hfc);
      check("pd0", pd0, 8'hff);
      check("pe0", pe0, 8'hff);
      wr_reg(8'h8c, 8'hff);
      rd_chk("ctl", 8'h8c, 8'h7f);
      wr_reg(8'h8c, 8'h08);
      @(posedge core_clk_i);
      v0 <= 8'h21;
      settle();
      rd_chk("flags0", 8'h89, 8'h21);
      check("i0 low", {7'h0, i0}, 8'h01);
      wr_reg(8'h8c, 8'h00);
      #1 check("i0 off", {7'h0, i0}, 8'h00);
      wr_reg(8'h8c, 8'h10);
      #1 check("i0 up", {7'h0, i0}, 8'h01);
      wr_reg(8'h89, 8'hdf);
      #1 check("i0 clr", {7'h0, i0}, 8'h00);
      rd_chk("flags0 clr", 8'h89, 8'h01);
      wr_reg(8'h8c, 8'h02);
      @(posedge core_clk_i);
      v1 <= 8'hfb;
      settle();
      rd_chk("flags1", 8'h8a, 8'h04);
      check("i1 mask", {7'h0, i1}, 8'h00);
      wr_reg(8'h8d, 8'h04);
      #1 check("i1 on", {7'h0, i1}, 8'h01);
      wr_reg(8'h8c, 8'h20);
      @(posedge core_clk_i);
      v2 <= 5'h10;
      settle();
      rd_chk("flags2", 8'h8b, 8'h10);
      check("i2", {7'h0, i2}, 8'h01);
      rd_chk("stat", 8'hc0, 8'h07);
      check("irq masked", {7'h0, irq}, 8'h00);
      wr_reg(8'hc1, 8'h04);
      #1 check("irq on", {7'h0, irq}, 8'h01);
      wr_reg(8'h8b, 8'h00);
      wr_reg(8'h8a, 8'h00);
      wr_reg(8'hc0, 8'h07);
      #1 check("irq clr", {7'h0, irq}, 8'h00);
      rd_chk("stat clr", 8'hc0, 8'h00);
      wr_reg(8'h8d, 8'h00);
      stop_test();
   end
endmodule : pif_port_irq_tb
